//--- inc/ptb_pkg.sv
/*
 * Constants for the PWM time base: register map, field layout, modes and
 * prescale codes.
 * Assumes a 32-bit Avalon-MM register port, one register per aligned word.
 */
package ptb_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses (word aligned).
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_A     = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B     = 4'h4;
    localparam logic [3:0] ADDR_COUNT      = 4'h8;
    localparam logic [3:0] ADDR_PERIOD_LOW = 4'hc;
    localparam logic [3:0] ADDR_PERIOD_HIGH = 4'h0;
    localparam logic [1:0] PAGE_LOW        = 2'h0;
    localparam logic [1:0] PAGE_HIGH       = 2'h1;

    // ------------------------------------------------------------------
    // Field layout.
    // ------------------------------------------------------------------
    localparam int MODE_LSB   = 0;
    localparam int PRESC_LSB  = 2;
    localparam int POSTS_LSB  = 4;
    localparam int ON_BIT     = 7;
    localparam int DIR_BIT    = 6;
    localparam int CNT_W      = 12;
    localparam int HIGH_W     = 4;

    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [11:0] COUNT_ZERO   = 12'h000;
    localparam logic [11:0] PERIOD_RESET = 12'h000;
    localparam logic [5:0]  PRE_ZERO     = 6'h00;
    localparam logic [3:0]  POST_ZERO    = 4'h0;

    // ------------------------------------------------------------------
    // Modes and prescale terminal counts.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PTB_FREE   = 2'b00,
        PTB_SINGLE = 2'b01,
        PTB_UPDN   = 2'b10,
        PTB_UPDN2  = 2'b11
    } ptb_mode_t;

    localparam logic [5:0] PRE_TC_1  = 6'h00;
    localparam logic [5:0] PRE_TC_4  = 6'h03;
    localparam logic [5:0] PRE_TC_16 = 6'h0f;
    localparam logic [5:0] PRE_TC_64 = 6'h3f;
endpackage : ptb_pkg

//--- src/ptb_timebase.sv
/*
 * PWM time base: 12-bit counter with prescaler, double-buffered period,
 * four count modes, direction flag and postscaled interrupt event.
 * Assumes mclk is the instruction clock (oscillator over four) and an
 * Avalon-MM master that holds each request until waitrequest is low.
 */
// Chosen here: the Avalon-MM slave port and the register offsets.
//
// Overview of operation
// - Free-running: count to period, wrap to zero
// - Single-shot: wrap at match, clear enable
// - Up/down: after period match count down
// - Read-only direction flag, one when down
// - Up/down modes: compare outputs inactive until first down-count
// - Input clock prescaled 1, 4, 16, 64
// - Prescaler cleared on count/control write, reset
// - Control writes never alter the count
// - Four-bit postscaler 1:1..1:16 before interrupt
// - Postscaler cleared on count/control write, reset
// - Free-running event at each period match
// - Single-shot one event, postscaler ignored
// - Up/down event when zero, upward begins
// - Double-update event at zero and at period
// - Period is 12 bits from two bytes
// - Edge modes load period on wrap to zero
// - Up/down modes load period at count zero
// - Disabled time base copies buffer continuously
// - Edge period is (period+1) times prescale
// - Up/down period is 2*period times prescale
// - Clearing enable does not clear count
`timescale 1ns/10ps
module ptb_timebase (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Avalon-MM register port
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Time base outputs to the compare units
    output logic      [11:0] timebase_count,
    output logic             count_dir_flag,
    output logic             compare_allow,
    output logic             tick,
    output logic             timebase_event
);
    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  match_postscale_sel;
        logic [1:0]  input_prescale_sel;
        logic [1:0]  timebase_mode_sel;
        logic        timebase_on;
        logic        dir;
        logic        allow;
        logic [11:0] count;
        logic [11:0] period_buf;
        logic [11:0] period_value;
        logic [5:0]  pre;
        logic [3:0]  post;
        logic        event_q;
        logic        tick_q;
        logic        ack;
        logic [31:0] rdata;
        logic        page;
    } ptb_state_t;

    ptb_state_t st;
    ptb_state_t next_st;

    logic [5:0] pre_tc;
    logic       tick_now;
    logic       wr_ctrl;
    logic       wr_count;
    logic       hit;
    logic       post_hit;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;

    // Prescale terminal count.
    always_comb begin
        unique case (st.input_prescale_sel)
            2'b00: pre_tc = ptb_pkg::PRE_TC_1;
            2'b01: pre_tc = ptb_pkg::PRE_TC_4;
            2'b10: pre_tc = ptb_pkg::PRE_TC_16;
            2'b11: pre_tc = ptb_pkg::PRE_TC_64;
        endcase
    end

    assign ctrl_a = {st.match_postscale_sel, st.input_prescale_sel, st.timebase_mode_sel};
    assign ctrl_b = {st.timebase_on, st.dir, 6'h00};

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.event_q = 1'b0;
        next_st.tick_q = 1'b0;
        hit = 1'b0;
        post_hit = 1'b0;
        // One wait state: request taken when ack is low, answered next cycle.
        next_st.ack = (avs_read | avs_write) & ~st.ack;
        wr_ctrl = 1'b0;
        wr_count = 1'b0;
        tick_now = st.timebase_on && (st.pre == pre_tc);

        if (st.timebase_on) begin
            next_st.pre = tick_now ? ptb_pkg::PRE_ZERO : st.pre + 6'h01;
        end

        if (tick_now) begin
            next_st.tick_q = 1'b1;
            unique case (st.timebase_mode_sel)
                ptb_pkg::PTB_FREE, ptb_pkg::PTB_SINGLE: begin
                    if (st.count == st.period_value) begin
                        next_st.count = ptb_pkg::COUNT_ZERO;
                        next_st.period_value = st.period_buf;
                        hit = 1'b1;
                        if (st.timebase_mode_sel == ptb_pkg::PTB_SINGLE) begin
                            next_st.timebase_on = 1'b0;
                            next_st.event_q = 1'b1;
                        end else begin
                            post_hit = 1'b1;
                        end
                    end else begin
                        next_st.count = st.count + 12'h001;
                    end
                end
                ptb_pkg::PTB_UPDN, ptb_pkg::PTB_UPDN2: begin
                    if (st.count == ptb_pkg::COUNT_ZERO) begin
                        next_st.period_value = st.period_buf;
                    end
                    if (!st.dir && st.count >= st.period_value) begin
                        next_st.dir = 1'b1;
                        next_st.allow = 1'b1;
                        next_st.count = st.count - 12'h001;
                        if (st.timebase_mode_sel == ptb_pkg::PTB_UPDN2) begin
                            post_hit = 1'b1;
                        end
                    end else if (st.dir && st.count == 12'h001) begin
                        next_st.count = st.count - 12'h001;
                    end else if (st.dir && st.count == ptb_pkg::COUNT_ZERO) begin
                        next_st.dir = 1'b0;
                        next_st.count = st.count + 12'h001;
                        post_hit = 1'b1;
                    end else begin
                        next_st.count = st.dir ? st.count - 12'h001 : st.count + 12'h001;
                    end
                end
            endcase
        end

        if (post_hit) begin
            if (st.post == st.match_postscale_sel) begin
                next_st.post = ptb_pkg::POST_ZERO;
                next_st.event_q = 1'b1;
            end else begin
                next_st.post = st.post + 4'h1;
            end
        end

        if (!st.timebase_on) begin
            next_st.period_value = st.period_buf;
        end

        // Register writes, taken at the first edge of the request.
        if (avs_write && !st.ack) begin
            unique case (avs_address)
                ptb_pkg::ADDR_CTRL_A: begin
                    if (avs_byteenable[0]) begin
                        next_st.timebase_mode_sel = avs_writedata[1:0];
                        next_st.input_prescale_sel = avs_writedata[3:2];
                        next_st.match_postscale_sel = avs_writedata[7:4];
                        next_st.page = avs_writedata[8];
                        wr_ctrl = 1'b1;
                    end
                end
                ptb_pkg::ADDR_CTRL_B: begin
                    if (avs_byteenable[0]) begin
                        next_st.timebase_on = avs_writedata[ptb_pkg::ON_BIT];
                        wr_ctrl = 1'b1;
                        // In up/down modes the first period after enable starts with outputs held.
                        if (avs_writedata[ptb_pkg::ON_BIT] && !st.timebase_on) begin
                            next_st.allow = ~st.timebase_mode_sel[1];
                        end
                    end
                end
                ptb_pkg::ADDR_COUNT: begin
                    if (avs_byteenable[0]) begin
                        next_st.count[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        next_st.count[11:8] = avs_writedata[11:8];
                    end
                    wr_count = |avs_byteenable[1:0];
                end
                ptb_pkg::ADDR_PERIOD_LOW: begin
                    if (avs_byteenable[0]) begin
                        next_st.period_buf[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        next_st.period_buf[11:8] = avs_writedata[11:8];
                    end
                end
                default: begin
                end
            endcase
        end

        // Hardware clear of enable in single-shot mode wins over a
        // same-cycle write only when the write does not target control B.
        if (wr_ctrl || wr_count) begin
            next_st.pre = ptb_pkg::PRE_ZERO;
            next_st.post = ptb_pkg::POST_ZERO;
        end
        if (wr_ctrl) begin
            next_st.count = st.count;
            next_st.dir = st.dir;
        end

        next_st.rdata = 32'h0;
        if (avs_read && !st.ack) begin
            unique case (avs_address)
                ptb_pkg::ADDR_CTRL_A: next_st.rdata = {24'h0, ctrl_a};
                ptb_pkg::ADDR_CTRL_B: next_st.rdata = {24'h0, ctrl_b};
                ptb_pkg::ADDR_COUNT: next_st.rdata = {20'h0, st.count};
                ptb_pkg::ADDR_PERIOD_LOW: next_st.rdata = {20'h0, st.period_buf};
                default: next_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
    assign avs_readdata    = st.rdata;
    assign timebase_count  = st.count;
    assign count_dir_flag  = st.dir;
    assign compare_allow   = st.allow;
    assign tick            = st.tick_q;
    assign timebase_event  = st.event_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    free_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel == 2'b00 && st.count == st.period_value
        && !avs_write |=> st.count == 12'h000) else $error("free wrap");
    single_stop_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel == 2'b01 && st.count == st.period_value
        && !avs_write |=> !st.timebase_on && timebase_event) else $error("single stop");
    turn_down_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel[1] && !st.dir && st.count == st.period_value
        && !avs_write |=> count_dir_flag) else $error("turn down");
    hold_off_a: assert property (@(posedge mclk) disable iff (!resetn)
        !st.timebase_on && !avs_write |=> $stable(st.count) && !timebase_event)
        else $error("hold off");
    ctrl_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
        wr_ctrl |=> $stable(st.count) && st.pre == 6'h00) else $error("ctrl keep");
    copy_off_a: assert property (@(posedge mclk) disable iff (!resetn)
        !st.timebase_on |=> st.period_value == $past(st.period_buf)) else $error("copy off");
    pre_tick_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now |=> tick && st.pre == 6'h00) else $error("pre tick");
    post_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
        wr_count |=> st.post == 4'h0) else $error("post clear");

    // ------------------------------------------------------------------
    // Bus checks.
    // ------------------------------------------------------------------
    one_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
        (avs_read || avs_write) && !st.ack
        |=> !avs_waitrequest)
        else $error("one wait");

    count_read_a: assert property (@(posedge mclk) disable iff (!resetn)
        avs_read && !st.ack && avs_address == ptb_pkg::ADDR_COUNT
        |=> avs_readdata == {20'h0, $past(st.count)})
        else $error("count read");

    dir_read_a: assert property (@(posedge mclk) disable iff (!resetn)
        avs_read && !st.ack && avs_address == ptb_pkg::ADDR_CTRL_B
        |=> avs_readdata[ptb_pkg::DIR_BIT] == $past(st.dir))
        else $error("dir read");

    // ------------------------------------------------------------------
    // Counter checks.
    // ------------------------------------------------------------------
    free_step_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel == ptb_pkg::PTB_FREE
        && st.count != st.period_value && !avs_write
        |=> st.count == $past(st.count) + 12'h001)
        else $error("free step");

    up_step_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel[1] && !st.dir
        && st.count < st.period_value && !avs_write
        |=> st.count == $past(st.count) + 12'h001 && !count_dir_flag)
        else $error("up step");

    down_step_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel[1] && st.dir
        && st.count != 12'h000 && !avs_write
        |=> st.count == $past(st.count) - 12'h001 && count_dir_flag)
        else $error("down step");

    zero_turn_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel[1] && st.dir
        && st.count == 12'h000 && !avs_write
        |=> st.count == 12'h001 && !count_dir_flag)
        else $error("zero turn");

    allow_late_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(compare_allow) && st.timebase_mode_sel[1]
        |-> count_dir_flag)
        else $error("allow late");

    // ------------------------------------------------------------------
    // Event checks.
    // ------------------------------------------------------------------
    free_event_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel == ptb_pkg::PTB_FREE
        && st.count == st.period_value && st.post == st.match_postscale_sel
        |=> timebase_event)
        else $error("free event");

    single_once_a: assert property (@(posedge mclk) disable iff (!resetn)
        timebase_event && st.timebase_mode_sel == ptb_pkg::PTB_SINGLE
        && !$past(avs_write)
        |-> !st.timebase_on)
        else $error("single once");

    updn_event_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel == ptb_pkg::PTB_UPDN && st.dir
        && st.count == 12'h000 && st.post == st.match_postscale_sel
        |=> timebase_event)
        else $error("updn event");

    double_top_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel == ptb_pkg::PTB_UPDN2 && !st.dir
        && st.count >= st.period_value && st.post == st.match_postscale_sel
        |=> timebase_event)
        else $error("double top");

    event_tick_a: assert property (@(posedge mclk) disable iff (!resetn)
        timebase_event
        |-> $past(tick_now))
        else $error("event tick");

    // ------------------------------------------------------------------
    // Buffer, prescale and postscale checks.
    // ------------------------------------------------------------------
    free_load_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && !st.timebase_mode_sel[1] && st.count == st.period_value
        |=> st.period_value == $past(st.period_buf))
        else $error("free load");

    updn_load_a: assert property (@(posedge mclk) disable iff (!resetn)
        tick_now && st.timebase_mode_sel[1] && st.count == 12'h000
        |=> st.period_value == $past(st.period_buf))
        else $error("updn load");

    pre_count_a: assert property (@(posedge mclk) disable iff (!resetn)
        wr_count
        |=> st.pre == 6'h00)
        else $error("pre count");

    post_ctrl_a: assert property (@(posedge mclk) disable iff (!resetn)
        wr_ctrl
        |=> st.post == 4'h0)
        else $error("post ctrl");
endmodule : ptb_timebase

//--- verif/ptb_timebase_bench.sv
/*
 * Self-checking bench for the PWM time base: register access, the four count
 * modes, prescale and postscale spacing, period buffering and hold on disable.
 * Assumes the one-wait-state Avalon-MM slave of ptb_timebase and a 25 MHz mclk.
 */
`timescale 1ns/10ps
module ptb_timebase_bench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        mclk;
    logic        resetn;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] timebase_count;
    logic        count_dir_flag;
    logic        compare_allow;
    logic        tick;
    logic        timebase_event;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    ptb_timebase ptb_timebase_i (
        .mclk            (mclk),
        .resetn          (resetn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .timebase_count  (timebase_count),
        .count_dir_flag  (count_dir_flag),
        .compare_allow   (compare_allow),
        .tick            (tick),
        .timebase_event  (timebase_event)
    );

    // ------------------------------------------------------------------
    // Clock, timeout and report
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // The slowest scenario needs a few thousand cycles; the ceiling is generous.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    // Waitrequest and read data are taken at the rising edge, before the design's
    // registers update, so the request stands unchanged at that edge.
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data,
                       output logic [31:0] q);
        @(posedge mclk);
        avs_address   <= addr;
        avs_writedata <= data;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] addr, input logic [31:0] data);
        logic [31:0] q;
        bus(1'b1, addr, data, q);
    endtask : wr

    task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, addr, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rd_chk

    // Mode is only changed with the time base off.
    task automatic start(input logic [7:0] cfg, input logic [11:0] per);
        wr(ptb_pkg::ADDR_CTRL_B, 32'h0000_0000);
        wr(ptb_pkg::ADDR_PERIOD_LOW, {20'h00000, per});
        wr(ptb_pkg::ADDR_COUNT, 32'h0000_0000);
        wr(ptb_pkg::ADDR_CTRL_A, {24'h000000, cfg});
        wr(ptb_pkg::ADDR_CTRL_B, 32'h0000_0080);
    endtask : start

    task automatic wait_ev(output int k);
        k = 0;
        while (timebase_event !== 1'b1 && k < 2000) begin
            @(negedge mclk);
            k++;
        end
    endtask : wait_ev

    task automatic gap(output int n, output logic [11:0] top);
        int k;
        wait_ev(k);
        n = 0;
        top = 12'h000;
        do begin
            @(negedge mclk);
            n++;
            if (timebase_count > top) top = timebase_count;
        end while (timebase_event !== 1'b1 && n < 2000);
    endtask : gap

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(ptb_pkg::ADDR_CTRL_A, 32'h0000_0000);
        rd_chk(ptb_pkg::ADDR_CTRL_B, 32'h0000_0000);
        rd_chk(ptb_pkg::ADDR_COUNT, 32'h0000_0000);
        rd_chk(ptb_pkg::ADDR_PERIOD_LOW, 32'h0000_0000);
        rd_chk(4'h2, 32'h0000_0000);
    endtask : t_reset

    task automatic t_free();
        int n;
        logic [11:0] top;
        for (int p = 0; p < 4; p++) begin
            start({4'h0, p[1:0], 2'b00}, 12'h003);
            gap(n, top);
            gap(n, top);
            chk(n, 32'd4 << (2 * p));
            chk(top, 32'h003);
        end
        start(8'h20, 12'h005);
        gap(n, top);
        gap(n, top);
        chk(n, 32'd18);
        wr(ptb_pkg::ADDR_PERIOD_LOW, 32'h0000_0009);
        repeat (3) gap(n, top);
        chk(n, 32'd30);
    endtask : t_free

    task automatic t_single();
        int k;
        start(8'h31, 12'h004);
        wait_ev(k);
        chk(k < 40, 1);
        repeat (4) @(negedge mclk);
        rd_chk(ptb_pkg::ADDR_CTRL_B, 32'h0000_0000);
        rd_chk(ptb_pkg::ADDR_COUNT, 32'h0000_0000);
        wait_ev(k);
        chk(k, 32'd2000);
    endtask : t_single

    task automatic t_updown();
        int n;
        int k;
        logic [11:0] top;
        logic [11:0] c1;
        start(8'h02, 12'h006);
        @(negedge mclk);
        chk(compare_allow, 1'b0);
        top = 12'h000;
        k = 0;
        while (count_dir_flag !== 1'b1 && k < 100) begin
            if (timebase_count > top) top = timebase_count;
            @(negedge mclk);
            k++;
        end
        chk(top, 32'h006);
        c1 = timebase_count;
        @(negedge mclk);
        chk(timebase_count, c1 - 12'h001);
        chk(compare_allow, 1'b1);
        gap(n, top);
        gap(n, top);
        chk(n, 32'd12);
        wr(ptb_pkg::ADDR_PERIOD_LOW, 32'h0000_0004);
        repeat (3) gap(n, top);
        chk(n, 32'd8);
        start(8'h03, 12'h006);
        gap(n, top);
        gap(n, top);
        chk(n, 32'd6);
    endtask : t_updown

    task automatic t_hold();
        int k;
        logic [31:0] q;
        start(8'h00, 12'h0c8);
        repeat (20) @(negedge mclk);
        chk(tick, 1'b1);
        wr(ptb_pkg::ADDR_CTRL_B, 32'h0000_0000);
        bus(1'b0, ptb_pkg::ADDR_COUNT, 32'h0000_0000, q);
        chk(q != 32'h0000_0000, 1);
        wait_ev(k);
        chk(k, 32'd2000);
        chk(tick, 1'b0);
        rd_chk(ptb_pkg::ADDR_COUNT, q);
        wr(ptb_pkg::ADDR_CTRL_A, 32'h0000_00f4);
        rd_chk(ptb_pkg::ADDR_COUNT, q);
        wr(ptb_pkg::ADDR_COUNT, 32'h0000_007a);
        rd_chk(ptb_pkg::ADDR_COUNT, 32'h0000_007a);
    endtask : t_hold

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn         = 1'b0;
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h3;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_free();
        t_single();
        t_updown();
        t_hold();
        final_report();
    end
endmodule : ptb_timebase_bench
